// ===== logic/spc_params.svh
// constants of the serial port configuration register bank
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH

`define SPC_ADDR_W        13
`define SPC_OFS_CONFIG    13'h000
`define SPC_OFS_VARIANT   13'h003
`define SPC_OFS_READBACK  13'h004
`define SPC_OFS_TAG_LO    13'h005
`define SPC_OFS_TAG_HI    13'h006
`define SPC_OFS_UPDATE    13'h232

`define SPC_BIT_MODE      7
`define SPC_BIT_ORDER     6
`define SPC_BIT_SRST      5
`define SPC_BIT_RB_ACTIVE 0
`define SPC_BIT_UPDATE    0

`define SPC_RST_MODE      1'b0
`define SPC_RST_ORDER     1'b0
`define SPC_RST_RB        1'b0
`define SPC_RST_TAG       8'h00

`define SPC_INSTR_LAST    5'h0F
`define SPC_BYTE_LAST     5'h07
`define SPC_INSTR_RW      15
`define SPC_LEN_STREAM    2'h3
`define SPC_PIN_RST       5'h02

`endif

// ===== logic/spc_pkg.sv
// types of the serial port configuration register bank
`include "spc_params.svh"

package spc_pkg;
  typedef logic [`SPC_ADDR_W-1:0] spc_addr_t;
  typedef logic [7:0]              spc_byte_t;

  typedef enum logic [3:0] {
    SPC_ST_IDLE  = 4'b0001,
    SPC_ST_INSTR = 4'b0010,
    SPC_ST_DATA  = 4'b0100,
    SPC_ST_HOLD  = 4'b1000
  } spc_port_state_t;

  typedef enum logic [2:0] {
    SPC_SR_IDLE    = 3'b001,
    SPC_SR_RESTORE = 3'b010,
    SPC_SR_LOAD    = 3'b100
  } spc_srst_state_t;
endpackage

// ===== logic/spc_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module spc_sync #(
  parameter int unsigned       WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             ref_clk_i,   // block clock
  input  wire logic             reset_n_i,   // async reset, active low
  input  wire logic [WIDTH-1:0] d_i,         // asynchronous pin levels
  output logic      [WIDTH-1:0] q_o          // levels in the clock domain
);
  logic [WIDTH-1:0] meta;

  if (WIDTH < 1) begin : g_chk
    $error("spc_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta <= RESET_VAL;
      q_o  <= RESET_VAL;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule // spc_sync

`default_nettype wire

// ===== logic/spc_soft_reset.sv
// soft reset sequencer: restore defaults, then optional nonvolatile load
`timescale 1ns/1ps
`default_nettype none

module spc_soft_reset (
  input  wire logic ref_clk_i,     // block clock
  input  wire logic reset_n_i,     // async reset, active low
  input  wire logic start_i,       // one-cycle soft reset request
  input  wire logic load_pin_i,    // synchronised nonvolatile-load pin
  input  wire logic load_done_i,   // nonvolatile load engine finished
  output logic      restore_o,     // one-cycle pulse: restore defaults
  output logic      load_req_o,    // level: nonvolatile load requested
  output logic      busy_o         // soft reset in progress
);
  import spc_pkg::*;

  spc_srst_state_t state;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state      <= SPC_SR_IDLE;
      restore_o  <= 1'b0;
      load_req_o <= 1'b0;
      busy_o     <= 1'b0;
    end else begin
      restore_o <= 1'b0;
      case (state)
        SPC_SR_IDLE: begin
          if (start_i) begin
            state     <= SPC_SR_RESTORE;
            restore_o <= 1'b1;
            busy_o    <= 1'b1;
          end
        end
        SPC_SR_RESTORE: begin
          // defaults land first so a partial load never leaves stale values
          if (load_pin_i) begin
            state      <= SPC_SR_LOAD;
            load_req_o <= 1'b1;
          end else begin
            state  <= SPC_SR_IDLE;
            busy_o <= 1'b0;
          end
        end
        SPC_SR_LOAD: begin
          if (load_done_i) begin
            state      <= SPC_SR_IDLE;
            load_req_o <= 1'b0;
            busy_o     <= 1'b0;
          end
        end
        default: begin
          state      <= SPC_SR_IDLE;
          load_req_o <= 1'b0;
          busy_o     <= 1'b0;
        end
      endcase
    end
  end
endmodule // spc_soft_reset

`default_nettype wire

// ===== logic/spc_regs_top.sv
// serial control port with its configuration register bank
//
// Notes on behaviour
// - mode bit 0: reads and writes on the data pin, separate output pin undriven.
// - mode bit 1: read data on the separate output pin, writes on the data pin.
// - order bit 0: most significant bit first, address decrements per byte.
// - order bit 1: least significant bit first, address increments per byte.
// - order bit is ignored while the port runs in the two-wire mode.
// - writing soft reset bit starts a reset; load pin high loads nonvolatile values.
// - load pin low at soft reset restores every register to its default.
// - read-only eight-bit variant code register identifies the fitted version.
// - readback select bit 0 picks buffer (0, reset) or active (1) registers.
// - sixteen-bit user tag in two byte registers, reset zero, no effect.
`timescale 1ns/1ps
`default_nettype none
`include "spc_params.svh"

module spc_regs_top #(
  parameter logic [7:0] VARIANT_CODE = 8'h5A   // arbitrary value
) (
  input  wire logic             ref_clk_i,              // 250 MHz block clock
  input  wire logic             reset_n_i,              // async reset, active low
  input  wire logic             sclk_i,                 // serial clock pin
  input  wire logic             cs_n_i,                 // chip select pin, active low
  input  wire logic             sdio_i,                 // data pin, input side
  output logic                  sdio_o,                 // data pin, output side
  output logic                  sdio_oe_o,              // data pin drive enable
  output logic                  serial_output_pin_o,    // separate read data pin
  output logic                  serial_output_pin_oe_o, // its drive enable
  input  wire logic             i2c_mode_i,             // port strapped to two-wire mode
  input  wire logic             eeprom_load_pin_i,      // nonvolatile-load pin
  output logic                  eeprom_load_req_o,      // nonvolatile load request
  input  wire logic             eeprom_load_done_i,     // load engine finished
  input  wire logic             eeprom_wr_en_i,         // load engine register write
  input  wire spc_pkg::spc_addr_t eeprom_wr_addr_i,     // load engine address
  input  wire spc_pkg::spc_byte_t eeprom_wr_data_i,     // load engine data
  output logic                  transfer_mode_select_o, // unidirectional mode active
  output logic                  lsb_first_o,            // stored bit order
  output logic                  readback_active_o,      // reads return active bank
  output logic                  soft_reset_busy_o,      // soft reset in progress
  output logic [15:0]           user_tag_o              // active user tag
);
  import spc_pkg::*;

  // pin synchronisation
  logic [4:0] pins_s;
  logic       s_sdio;
  logic       s_cs_n;
  logic       s_sclk;
  logic       s_i2c;
  logic       s_load_pin;
  logic       sclk_q;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       lsb_eff;

  spc_sync #(
    .WIDTH     (5),
    .RESET_VAL (`SPC_PIN_RST)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .d_i       ({eeprom_load_pin_i, i2c_mode_i, sdio_i, cs_n_i, sclk_i}),
    .q_o       (pins_s)
  );

  assign s_load_pin = pins_s[4];
  assign s_i2c      = pins_s[3];
  assign s_sdio     = pins_s[2];
  assign s_cs_n     = pins_s[1];
  assign s_sclk     = pins_s[0];

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= s_sclk;
    end
  end

  assign sclk_rise = s_sclk & ~sclk_q;
  assign sclk_fall = ~s_sclk & sclk_q;

  // register storage
  logic      mode_q;
  logic      order_q;
  logic      rb_q;
  spc_byte_t tag_buf_lo;
  spc_byte_t tag_buf_hi;
  spc_byte_t tag_act_lo;
  spc_byte_t tag_act_hi;
  logic      wr_stb;
  spc_addr_t wr_addr;
  spc_byte_t wr_data;
  logic      srst_start;
  logic      srst_restore;
  logic      srst_busy;

  assign lsb_eff = order_q & ~s_i2c;

  assign srst_start = wr_stb && (wr_addr == `SPC_OFS_CONFIG)
                      && wr_data[`SPC_BIT_SRST] && !srst_busy;

  spc_soft_reset u_srst (
    .ref_clk_i   (ref_clk_i),
    .reset_n_i   (reset_n_i),
    .start_i     (srst_start),
    .load_pin_i  (s_load_pin),
    .load_done_i (eeprom_load_done_i),
    .restore_o   (srst_restore),
    .load_req_o  (eeprom_load_req_o),
    .busy_o      (srst_busy)
  );

  assign soft_reset_busy_o      = srst_busy;
  assign transfer_mode_select_o = mode_q;
  assign lsb_first_o            = order_q;
  assign readback_active_o      = rb_q;
  assign user_tag_o             = {tag_act_hi, tag_act_lo};

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_q     <= `SPC_RST_MODE;
      order_q    <= `SPC_RST_ORDER;
      rb_q       <= `SPC_RST_RB;
      tag_buf_lo <= `SPC_RST_TAG;
      tag_buf_hi <= `SPC_RST_TAG;
      tag_act_lo <= `SPC_RST_TAG;
      tag_act_hi <= `SPC_RST_TAG;
    end else if (srst_restore) begin
      mode_q     <= `SPC_RST_MODE;
      order_q    <= `SPC_RST_ORDER;
      rb_q       <= `SPC_RST_RB;
      tag_buf_lo <= `SPC_RST_TAG;
      tag_buf_hi <= `SPC_RST_TAG;
      tag_act_lo <= `SPC_RST_TAG;
      tag_act_hi <= `SPC_RST_TAG;
    end else if (eeprom_wr_en_i) begin
      // stored settings take effect at once: both banks are written
      case (eeprom_wr_addr_i)
        `SPC_OFS_CONFIG: begin
          mode_q  <= eeprom_wr_data_i[`SPC_BIT_MODE];
          order_q <= eeprom_wr_data_i[`SPC_BIT_ORDER];
        end
        `SPC_OFS_READBACK: rb_q <= eeprom_wr_data_i[`SPC_BIT_RB_ACTIVE];
        `SPC_OFS_TAG_LO: begin
          tag_buf_lo <= eeprom_wr_data_i;
          tag_act_lo <= eeprom_wr_data_i;
        end
        `SPC_OFS_TAG_HI: begin
          tag_buf_hi <= eeprom_wr_data_i;
          tag_act_hi <= eeprom_wr_data_i;
        end
        default: begin
        end
      endcase
    end else if (wr_stb) begin
      case (wr_addr)
        `SPC_OFS_CONFIG: begin
          // low nibble is only the mirror, so the upper bits alone are kept
          mode_q  <= wr_data[`SPC_BIT_MODE];
          order_q <= wr_data[`SPC_BIT_ORDER];
        end
        `SPC_OFS_READBACK: rb_q <= wr_data[`SPC_BIT_RB_ACTIVE];
        `SPC_OFS_TAG_LO:   tag_buf_lo <= wr_data;
        `SPC_OFS_TAG_HI:   tag_buf_hi <= wr_data;
        `SPC_OFS_UPDATE: begin
          if (wr_data[`SPC_BIT_UPDATE]) begin
            tag_act_lo <= tag_buf_lo;
            tag_act_hi <= tag_buf_hi;
          end
        end
        default: begin
        end
      endcase
    end
  end

  function automatic spc_byte_t read_reg(input spc_addr_t a);
    spc_byte_t v;
    v = 8'h00;
    case (a)
      `SPC_OFS_CONFIG:   v = {mode_q, order_q, srst_busy, 1'b0,
                              1'b0, srst_busy, order_q, mode_q};
      `SPC_OFS_VARIANT:  v = VARIANT_CODE;
      `SPC_OFS_READBACK: v = {7'h00, rb_q};
      `SPC_OFS_TAG_LO:   v = rb_q ? tag_act_lo : tag_buf_lo;
      `SPC_OFS_TAG_HI:   v = rb_q ? tag_act_hi : tag_buf_hi;
      default:           v = 8'h00;
    endcase
    return v;
  endfunction

  // serial port engine
  spc_port_state_t state;
  logic [4:0]      bit_cnt;
  logic [15:0]     sr;
  logic [15:0]     next_sr;
  spc_addr_t       addr;
  spc_addr_t       next_addr;
  logic            is_read;
  logic [1:0]      len;
  logic [1:0]      bytes_left;
  spc_byte_t       tx_byte;
  spc_byte_t       rx_byte;
  logic            tx_bit;
  logic            last_byte;

  assign next_sr   = lsb_eff ? {s_sdio, sr[15:1]} : {sr[14:0], s_sdio};
  assign rx_byte   = lsb_eff ? next_sr[15:8] : next_sr[7:0];
  assign next_addr = lsb_eff ? spc_addr_t'(addr + 1'b1)
                             : spc_addr_t'(addr - 1'b1);
  assign tx_bit    = lsb_eff ? tx_byte[bit_cnt[2:0]]
                             : tx_byte[3'h7 - bit_cnt[2:0]];
  assign last_byte = (len != `SPC_LEN_STREAM) && (bytes_left == 2'h0);

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state                  <= SPC_ST_IDLE;
      bit_cnt                <= 5'h00;
      sr                     <= 16'h0000;
      addr                   <= '0;
      is_read                <= 1'b0;
      len                    <= 2'h0;
      bytes_left             <= 2'h0;
      tx_byte                <= 8'h00;
      wr_stb                 <= 1'b0;
      wr_addr                <= '0;
      wr_data                <= 8'h00;
      sdio_o                 <= 1'b0;
      sdio_oe_o              <= 1'b0;
      serial_output_pin_o    <= 1'b0;
      serial_output_pin_oe_o <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      if (s_cs_n) begin
        // deselect aborts any transfer and releases both pins
        state                  <= SPC_ST_IDLE;
        sdio_oe_o              <= 1'b0;
        serial_output_pin_oe_o <= 1'b0;
      end else begin
        case (state)
          SPC_ST_IDLE: begin
            state   <= SPC_ST_INSTR;
            bit_cnt <= 5'h00;
          end
          SPC_ST_INSTR: begin
            if (sclk_rise) begin
              sr      <= next_sr;
              bit_cnt <= bit_cnt + 5'h01;
              if (bit_cnt == `SPC_INSTR_LAST) begin
                bit_cnt    <= 5'h00;
                is_read    <= next_sr[`SPC_INSTR_RW];
                len        <= next_sr[14:13];
                bytes_left <= next_sr[14:13];
                addr       <= next_sr[12:0];
                tx_byte    <= read_reg(next_sr[12:0]);
                state      <= SPC_ST_DATA;
              end
            end
          end
          SPC_ST_DATA: begin
            if (sclk_fall && is_read) begin
              sdio_o                 <= tx_bit;
              serial_output_pin_o    <= tx_bit;
              sdio_oe_o              <= ~mode_q;
              serial_output_pin_oe_o <= mode_q;
            end
            if (sclk_rise) begin
              sr      <= next_sr;
              bit_cnt <= bit_cnt + 5'h01;
              if (bit_cnt == `SPC_BYTE_LAST) begin
                bit_cnt    <= 5'h00;
                addr       <= next_addr;
                bytes_left <= bytes_left - 2'h1;
                if (is_read) begin
                  tx_byte <= read_reg(next_addr);
                end else begin
                  wr_stb  <= 1'b1;
                  wr_addr <= addr;
                  wr_data <= rx_byte;
                end
                if (last_byte) begin
                  state                  <= SPC_ST_HOLD;
                  sdio_oe_o              <= 1'b0;
                  serial_output_pin_oe_o <= 1'b0;
                end
              end
            end
          end
          SPC_ST_HOLD: begin
            state <= SPC_ST_HOLD;
          end
          default: begin
            state <= SPC_ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // spc_regs_top

`default_nettype wire

// ===== bench/spc_regs_monitor.sv
// checker for the configuration register bank ports
`timescale 1ns/1ps
`default_nettype none

module spc_regs_monitor (
  input wire logic        ref_clk_i,              // clock
  input wire logic        reset_n_i,              // reset
  input wire logic        cs_n_i,                 // select pin
  input wire logic        sdio_oe_o,              // data enable
  input wire logic        serial_output_pin_oe_o, // sep enable
  input wire logic        eeprom_load_done_i,     // load done
  input wire logic        eeprom_load_req_o,      // load request
  input wire logic        transfer_mode_select_o, // mode
  input wire logic        lsb_first_o,            // order
  input wire logic        readback_active_o,      // bank select
  input wire logic        soft_reset_busy_o,      // busy
  input wire logic [15:0] user_tag_o              // tag
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_bidir_sep_off: assert property (!transfer_mode_select_o |-> !serial_output_pin_oe_o)
    else $error("separate pin driven in bidirectional mode");
  a_unidir_sdio_off: assert property (transfer_mode_select_o |-> !sdio_oe_o)
    else $error("data pin driven in unidirectional mode");
  // the pin takes three clocks to be seen, so allow six before blaming the device
  a_read_in_frame: assert property (
    (sdio_oe_o || serial_output_pin_oe_o) |-> !$past(cs_n_i, 6))
    else $error("read data driven outside a frame");
  a_load_in_busy: assert property (eeprom_load_req_o |-> soft_reset_busy_o)
    else $error("load request outside soft reset");
  a_load_holds: assert property (
    eeprom_load_req_o && !eeprom_load_done_i |=> eeprom_load_req_o)
    else $error("load request dropped before done");
  a_restore_defaults: assert property (
    $rose(soft_reset_busy_o) |-> ##[0:2]
    (!transfer_mode_select_o && !lsb_first_o && !readback_active_o
     && user_tag_o == 16'h0000))
    else $error("defaults not restored by soft reset");
  a_restore_short: assert property (
    soft_reset_busy_o && !eeprom_load_req_o |-> ##[0:4]
    (!soft_reset_busy_o || eeprom_load_req_o))
    else $error("soft reset without load did not end");
  a_tag_change_cause: assert property (
    $changed(user_tag_o) |->
    (!$past(cs_n_i, 4) || soft_reset_busy_o || $past(soft_reset_busy_o)))
    else $error("active tag changed without a cause");
  a_cfg_change_cause: assert property (
    $changed({transfer_mode_select_o, lsb_first_o, readback_active_o}) |->
    (!$past(cs_n_i, 4) || soft_reset_busy_o || $past(soft_reset_busy_o)))
    else $error("configuration changed without a cause");
endmodule // spc_regs_monitor

`default_nettype wire

// ===== bench/spc_host_model.sv
// serial port host model for the configuration register bank
`timescale 1ns/1ps
`default_nettype none

module spc_host_model (
  input  wire logic ref_clk_i, // clock
  input  wire logic sdio_o,    // device data
  input  wire logic sdio_oe_o, // device data enable
  input  wire logic sep_o,     // separate pin
  input  wire logic sep_oe_o,  // separate pin enable
  output logic      sclk_o,    // serial clock
  output logic      cs_n_o,    // chip select
  output logic      sdio_w_o   // resolved data line
);
  logic drv_en = 1'b0;
  logic drv_bit = 1'b0;
  initial sclk_o = 1'b0;
  initial cs_n_o = 1'b1;
  // a released line shows the inverse of the last bit, never a stale copy
  assign sdio_w_o = sdio_oe_o ? sdio_o : (drv_en ? drv_bit : ~drv_bit);
  wire sep_w = sep_oe_o ? sep_o : ~drv_bit;

  task automatic xfer(input logic [15:0] ins, input int nb, input logic [15:0] wd,
                      input bit lsb, input bit sep, output logic [15:0] rd);
    int p;
    rd = 16'h0000;
    @(posedge ref_clk_i);
    cs_n_o <= 1'b0;
    for (int i = 0; i < 16 + 8 * nb; i++) begin
      if (i < 16) begin
        p = lsb ? i : 15 - i;
        drv_bit <= ins[p];
      end else begin
        p = 8 * ((i - 16) / 8) + (lsb ? (i - 16) % 8 : 7 - (i - 16) % 8);
        drv_bit <= wd[p];
      end
      drv_en <= (i < 16) || !ins[15];
      repeat (6) @(posedge ref_clk_i);
      sclk_o <= 1'b1;
      if (i >= 16) rd[p] = sep ? sep_w : sdio_w_o;
      repeat (6) @(posedge ref_clk_i);
      sclk_o <= 1'b0;
    end
    repeat (6) @(posedge ref_clk_i);
    cs_n_o <= 1'b1;
    drv_en <= 1'b0;
    repeat (12) @(posedge ref_clk_i);
  endtask
endmodule // spc_host_model

`default_nettype wire

// ===== bench/spc_regs_tb_top.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none

module spc_regs_tb_top;
  import spc_pkg::*;
  // arbitrary value; not a bit palindrome, so a reversed shift order shows
  localparam logic [7:0] VAR_CODE = 8'h3A; // arbitrary value
  logic        ref_clk, reset_n, i2c_mode, load_pin, load_done, ld_en;
  spc_addr_t   ld_addr;
  spc_byte_t   ld_data;
  logic        sclk, cs_n, sdio_w, sdio_o, sdio_oe, sep, sep_oe;
  logic        load_req, mode_o, lsb_o, rb_o, busy;
  logic [15:0] tag, rdv;
  bit          lsb_cur, sep_cur;
  int          err_count, tests_run, cyc;

  spc_regs_top #(.VARIANT_CODE(VAR_CODE)) uut (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
    .sclk_i(sclk), .cs_n_i(cs_n), .sdio_i(sdio_w), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe),
    .serial_output_pin_o(sep), .serial_output_pin_oe_o(sep_oe), .i2c_mode_i(i2c_mode),
    .eeprom_load_pin_i(load_pin), .eeprom_load_req_o(load_req), .eeprom_load_done_i(load_done),
    .eeprom_wr_en_i(ld_en), .eeprom_wr_addr_i(ld_addr), .eeprom_wr_data_i(ld_data),
    .transfer_mode_select_o(mode_o), .lsb_first_o(lsb_o), .readback_active_o(rb_o),
    .soft_reset_busy_o(busy), .user_tag_o(tag));
  spc_host_model host (.ref_clk_i(ref_clk), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe), .sep_o(sep),
    .sep_oe_o(sep_oe), .sclk_o(sclk), .cs_n_o(cs_n), .sdio_w_o(sdio_w));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic results();
    $display("mismatches %0d, checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      $display("unexpected at %0t: run did not finish", $time);
      results();
    end
  end

  task automatic chk_rd(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: read %h want %h", $time, g, e);
    end
  endtask

  task automatic chk_pin(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: port %h want %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [12:0] a, input int nb, input logic [15:0] d);
    host.xfer({1'b0, 2'(nb - 1), a}, nb, d, lsb_cur, sep_cur, rdv);
  endtask

  task automatic rc(input logic [12:0] a, input logic [7:0] e);
    host.xfer({1'b1, 2'b00, a}, 1, 16'h0000, lsb_cur, sep_cur, rdv);
    chk_rd(rdv[7:0], e);
  endtask

  task automatic s_reset_vals();
    rc(13'h000, 8'h00);
    rc(13'h003, VAR_CODE);
    rc(13'h004, 8'h00);
    rc(13'h005, 8'h00);
    rc(13'h006, 8'h00);
    wr(13'h003, 1, 16'h00FF);
    rc(13'h003, VAR_CODE);
    wr(13'h010, 1, 16'h00FF);
    rc(13'h010, 8'h00);
  endtask

  task automatic s_buffer();
    wr(13'h006, 2, 16'h3412);
    chk_pin(tag, 16'h0000);
    rc(13'h005, 8'h34);
    wr(13'h004, 1, 16'h0001);
    chk_pin({15'h0000, rb_o}, 16'h0001);
    rc(13'h006, 8'h00);
    wr(13'h232, 1, 16'h0001);
    chk_pin(tag, 16'h1234);
    rc(13'h006, 8'h12);
  endtask

  task automatic s_unidir();
    wr(13'h000, 1, 16'h0081);
    chk_pin({15'h0000, mode_o}, 16'h0001);
    sep_cur = 1'b1;
    rc(13'h003, VAR_CODE);
    wr(13'h000, 1, 16'h0000);
    sep_cur = 1'b0;
    chk_pin({15'h0000, mode_o}, 16'h0000);
    rc(13'h003, VAR_CODE);
  endtask

  task automatic s_lsb();
    wr(13'h000, 1, 16'h0042);
    lsb_cur = 1'b1;
    chk_pin({15'h0000, lsb_o}, 16'h0001);
    rc(13'h000, 8'h42);
    wr(13'h005, 2, 16'h7856);
    wr(13'h232, 1, 16'h0001);
    chk_pin(tag, 16'h7856);
    rc(13'h006, 8'h78);
  endtask

  task automatic s_i2c();
    i2c_mode <= 1'b1;
    repeat (6) @(posedge ref_clk);
    lsb_cur = 1'b0;
    rc(13'h006, 8'h78);
    i2c_mode <= 1'b0;
    repeat (6) @(posedge ref_clk);
    lsb_cur = 1'b1;
  endtask

  task automatic s_srst_low();
    // mode and order are set by the same write, so only the restore can clear them
    wr(13'h000, 1, 16'h00E7);
    for (int i = 0; i < 50 && busy !== 1'b0; i++) @(posedge ref_clk);
    lsb_cur = 1'b0;
    chk_pin({11'h000, load_req, mode_o, lsb_o, rb_o, busy}, 16'h0000);
    chk_pin(tag, 16'h0000);
    rc(13'h000, 8'h00);
    rc(13'h005, 8'h00);
  endtask

  task automatic s_srst_load();
    load_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    wr(13'h000, 1, 16'h0024);
    chk_pin({14'h0000, load_req, busy}, 16'h0003);
    ld_en <= 1'b1;
    ld_addr <= 13'h005;
    ld_data <= 8'hAB;
    @(posedge ref_clk);
    ld_addr <= 13'h006;
    ld_data <= 8'hCD;
    @(posedge ref_clk);
    ld_addr <= 13'h004;
    ld_data <= 8'h01;
    @(posedge ref_clk);
    ld_en <= 1'b0;
    load_done <= 1'b1;
    @(posedge ref_clk);
    load_done <= 1'b0;
    for (int i = 0; i < 50 && busy !== 1'b0; i++) @(posedge ref_clk);
    chk_pin(tag, 16'hCDAB);
    chk_pin({14'h0000, load_req, rb_o}, 16'h0001);
    rc(13'h005, 8'hAB);
    load_pin <= 1'b0;
  endtask

  initial begin
    reset_n = 1'b0;
    i2c_mode = 1'b0;
    load_pin = 1'b0;
    load_done = 1'b0;
    ld_en = 1'b0;
    ld_addr = 13'h000;
    ld_data = 8'h00;
    lsb_cur = 1'b0;
    sep_cur = 1'b0;
    err_count = 0;
    tests_run = 0;
    cyc = 0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    s_reset_vals();
    s_buffer();
    s_unidir();
    s_lsb();
    s_i2c();
    s_srst_low();
    s_srst_load();
    results();
  end
endmodule // spc_regs_tb_top

bind spc_regs_top spc_regs_monitor mon (.ref_clk_i, .reset_n_i, .cs_n_i, .sdio_oe_o,
  .serial_output_pin_oe_o, .eeprom_load_done_i, .eeprom_load_req_o, .transfer_mode_select_o,
  .lsb_first_o, .readback_active_o, .soft_reset_busy_o, .user_tag_o);

`default_nettype wire
